//--- mssf_pkg.sv
// Package with the constants of the security tag framer.
package mssf_pkg;

    // ****************************************
    // Frame layout
    // ****************************************
    localparam logic [3:0] ADDR_LEN = 4'hC;
    localparam logic [15:0] SEC_ETYPE = 16'h88E5;
    localparam logic [3:0] TAG_LEN_BASE = 4'h8;
    localparam logic [4:0] TAG_LEN_SCI = 5'h10;
    localparam logic [4:0] ICV_LEN = 5'h10;
    localparam logic [15:0] MIN_MPDU = 16'h0011;

    // ****************************************
    // Byte positions inside a received frame
    // ****************************************
    localparam logic [15:0] POS_ETYPE_HI = 16'h000C;
    localparam logic [15:0] POS_ETYPE_LO = 16'h000D;
    localparam logic [15:0] POS_TCI = 16'h000E;
    localparam logic [15:0] POS_SL = 16'h000F;
    localparam logic [15:0] POS_PN_FIRST = 16'h0010;
    localparam logic [15:0] POS_PN_LAST = 16'h0013;
    localparam logic [15:0] POS_SCI_FIRST = 16'h0014;
    localparam logic [15:0] POS_SCI_LAST = 16'h001B;

    // ****************************************
    // Tag control byte and short length fields
    // ****************************************
    localparam int TCI_V = 7;
    localparam int TCI_ES = 6;
    localparam int TCI_SC = 5;
    localparam int TCI_SCB = 4;
    localparam int TCI_E = 3;
    localparam int TCI_C = 2;
    localparam logic [15:0] SL_LIMIT = 16'h0030;
    localparam logic [5:0] SL_ZERO = 6'h00;
    localparam logic [1:0] SL_RSVD = 2'h0;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [31:0] PN_RESET = 32'h00000001;
    localparam logic [31:0] PN_START = 32'h00000001;

    // ****************************************
    // Transmit states
    // ****************************************
    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_ADDR = 3'h1,
        TX_TAG = 3'h2,
        TX_DATA = 3'h3,
        TX_ICV = 3'h4
    } mssf_tx_state_e;

    // Picks byte idx, most significant first, of a 128-bit vector.
    function automatic logic [7:0] byte_of(input logic [127:0] vec,
                                           input logic [3:0] idx);
        logic [127:0] sh;
        sh = vec << {idx, 3'h0};
        return sh[127:120];
    endfunction

endpackage

//--- mssf_pn_counter.sv
// Transmit packet number counter of the security association.
`timescale 1ns/1ps
module mssf_pn_counter (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Load from the key agreement entity.
    input wire logic load,
    input wire logic [31:0] load_value,
    // One pulse per secured frame.
    input wire logic inc,
    // Current packet number.
    output logic [31:0] pn
);

    logic [31:0] pn_r;
    logic [31:0] pn_nxt;

    assign pn_nxt = load ? load_value : (inc ? pn_r + 32'h00000001 : pn_r);
    assign pn = pn_r;

    always_ff @(posedge clk)
    begin
        if (!resetn)
            pn_r <= mssf_pkg::PN_RESET;
        else
            pn_r <= pn_nxt;
    end

endmodule // mssf_pn_counter

//--- mssf_iv_gen.sv
// Initial value builder for the crypto engines.
`timescale 1ns/1ps
module mssf_iv_gen (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Capture strobe and sources.
    input wire logic capture,
    input wire logic [63:0] sci,
    input wire logic [31:0] pn,
    // Initial value, channel identifier then packet number.
    output logic [95:0] iv
);

    logic [95:0] iv_r;

    assign iv = iv_r;

    always_ff @(posedge clk)
    begin
        if (!resetn)
            iv_r <= 96'h0;
        else if (capture)
            iv_r <= {sci, pn};
    end

endmodule // mssf_iv_gen

//--- mssf_framer.sv
// Security tag framer: tag insertion on transmit, tag parsing on receive.
`timescale 1ns/1ps
module mssf_framer (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Transmit frame in, one byte per cycle.
    input wire logic tx_in_valid,
    input wire logic [7:0] tx_in_data,
    input wire logic tx_in_sof,
    input wire logic tx_in_eof,
    output logic tx_in_ready,
    // Per frame transmit control, sampled with the first byte; tx_icv is sampled with the last byte.
    input wire logic tx_secure,
    input wire logic tx_encrypt,
    input wire logic tx_include_sci,
    input wire logic [1:0] tx_an,
    input wire logic [15:0] tx_user_len,
    input wire logic [127:0] tx_icv,
    // Channel configuration.
    input wire logic [47:0] src_mac,
    input wire logic [15:0] port_num,
    input wire logic pn_load,
    input wire logic [31:0] pn_load_value,
    // Transmit frame out.
    output logic tx_out_valid,
    output logic [7:0] tx_out_data,
    output logic tx_out_sof,
    output logic tx_out_eof,
    // Transmit status.
    output logic [31:0] tx_pn,
    output logic [95:0] tx_iv,
    // Receive frame in.
    input wire logic rx_in_valid,
    input wire logic [7:0] rx_in_data,
    input wire logic rx_in_sof,
    input wire logic rx_in_eof,
    // Receive frame out, unchanged, one cycle later.
    output logic rx_out_valid,
    output logic [7:0] rx_out_data,
    output logic rx_out_sof,
    output logic rx_out_eof,
    // Receive decode, valid with rx_status_valid.
    output logic rx_status_valid,
    output logic rx_secured,
    output logic rx_kay,
    output logic rx_drop,
    output logic rx_encrypted,
    output logic rx_changed,
    output logic [1:0] rx_an,
    output logic [5:0] rx_sl,
    output logic [31:0] rx_pn,
    output logic [63:0] rx_sci,
    output logic [95:0] rx_iv
);

    // ****************************************
    // Transmit control capture
    // ****************************************
    mssf_pkg::mssf_tx_state_e st_r;
    mssf_pkg::mssf_tx_state_e st_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic sec_r;
    logic enc_r;
    logic sci_en_r;
    logic [1:0] an_r;
    logic [5:0] sl_r;
    logic [127:0] icv_r;
    logic ov_r;
    logic ov_nxt;
    logic [7:0] od_r;
    logic [7:0] od_nxt;
    logic osof_r;
    logic osof_nxt;
    logic oeof_r;
    logic oeof_nxt;
    logic pn_inc;
    logic tx_acc;
    logic start;
    logic [7:0] tci;
    logic [127:0] tag_vec;
    logic [3:0] tag_last;
    logic [63:0] tx_sci;
    logic [5:0] sl_calc;

    assign tx_in_ready = (st_r == mssf_pkg::TX_IDLE)
        || (st_r == mssf_pkg::TX_ADDR) || (st_r == mssf_pkg::TX_DATA);
    assign tx_acc = tx_in_valid && tx_in_ready;
    assign start = tx_acc && tx_in_sof && (st_r == mssf_pkg::TX_IDLE);
    assign sl_calc = (tx_user_len < mssf_pkg::SL_LIMIT)
        ? tx_user_len[5:0] : mssf_pkg::SL_ZERO;
    assign tx_sci = {src_mac, port_num};
    // C follows E, so E clear with C set never leaves.
    assign tci = {1'b0, 1'b0, sci_en_r, 1'b0, enc_r, enc_r, an_r};
    assign tag_vec = {mssf_pkg::SEC_ETYPE, tci, mssf_pkg::SL_RSVD, sl_r,
        tx_pn, tx_sci};
    assign tag_last = sci_en_r ? 4'(mssf_pkg::TAG_LEN_SCI - 5'h01)
        : 4'(mssf_pkg::TAG_LEN_BASE - 4'h1);

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sec_r <= 1'b0;
            enc_r <= 1'b0;
            sci_en_r <= 1'b0;
            an_r <= 2'h0;
            sl_r <= 6'h00;
        end
        else if (start)
        begin
            sec_r <= tx_secure;
            enc_r <= tx_encrypt;
            sci_en_r <= tx_include_sci;
            an_r <= tx_an;
            sl_r <= sl_calc;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            icv_r <= 128'h0;
        else if (st_r == mssf_pkg::TX_DATA && tx_acc && tx_in_eof)
            icv_r <= tx_icv;
    end

    // ****************************************
    // Transmit sequencer
    // ****************************************
    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        ov_nxt = 1'b0;
        od_nxt = od_r;
        osof_nxt = 1'b0;
        oeof_nxt = 1'b0;
        pn_inc = 1'b0;
        unique case (st_r)
            mssf_pkg::TX_IDLE:
            begin
                if (start)
                begin
                    ov_nxt = 1'b1;
                    od_nxt = tx_in_data;
                    osof_nxt = 1'b1;
                    cnt_nxt = 4'h1;
                    st_nxt = mssf_pkg::TX_ADDR;
                end
            end
            mssf_pkg::TX_ADDR:
            begin
                if (tx_acc)
                begin
                    ov_nxt = 1'b1;
                    od_nxt = tx_in_data;
                    if (cnt_r == mssf_pkg::ADDR_LEN - 4'h1)
                    begin
                        cnt_nxt = 4'h0;
                        st_nxt = sec_r ? mssf_pkg::TX_TAG
                            : mssf_pkg::TX_DATA;
                    end
                    else
                        cnt_nxt = cnt_r + 4'h1;
                end
            end
            mssf_pkg::TX_TAG:
            begin
                ov_nxt = 1'b1;
                od_nxt = mssf_pkg::byte_of(tag_vec, cnt_r);
                if (cnt_r == tag_last)
                begin
                    cnt_nxt = 4'h0;
                    pn_inc = 1'b1;
                    st_nxt = mssf_pkg::TX_DATA;
                end
                else
                    cnt_nxt = cnt_r + 4'h1;
            end
            mssf_pkg::TX_DATA:
            begin
                if (tx_acc)
                begin
                    ov_nxt = 1'b1;
                    od_nxt = tx_in_data;
                    if (tx_in_eof)
                    begin
                        cnt_nxt = 4'h0;
                        oeof_nxt = !sec_r;
                        st_nxt = sec_r ? mssf_pkg::TX_ICV
                            : mssf_pkg::TX_IDLE;
                    end
                end
            end
            mssf_pkg::TX_ICV:
            begin
                ov_nxt = 1'b1;
                od_nxt = mssf_pkg::byte_of(icv_r, cnt_r);
                if (cnt_r == 4'(mssf_pkg::ICV_LEN - 5'h01))
                begin
                    oeof_nxt = 1'b1;
                    st_nxt = mssf_pkg::TX_IDLE;
                end
                else
                    cnt_nxt = cnt_r + 4'h1;
            end
            default:
                st_nxt = mssf_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_r <= mssf_pkg::TX_IDLE;
            cnt_r <= 4'h0;
            ov_r <= 1'b0;
            od_r <= 8'h00;
            osof_r <= 1'b0;
            oeof_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            ov_r <= ov_nxt;
            od_r <= od_nxt;
            osof_r <= osof_nxt;
            oeof_r <= oeof_nxt;
        end
    end

    assign tx_out_valid = ov_r;
    assign tx_out_data = od_r;
    assign tx_out_sof = osof_r;
    assign tx_out_eof = oeof_r;

    mssf_pn_counter u_pn (
        .clk(clk),
        .resetn(resetn),
        .load(pn_load),
        .load_value(pn_load_value),
        .inc(pn_inc),
        .pn(tx_pn)
    );

    mssf_iv_gen u_tx_iv (
        .clk(clk),
        .resetn(resetn),
        .capture(st_r == mssf_pkg::TX_TAG && cnt_r == 4'h0),
        .sci(tx_sci),
        .pn(tx_pn),
        .iv(tx_iv)
    );

    // ****************************************
    // Receive parser
    // ****************************************
    logic [15:0] pos_r;
    logic [15:0] idx;
    logic [7:0] et_hi_r;
    logic is_sec_r;
    logic [7:0] rtci_r;
    logic [7:0] rsl_r;
    logic [31:0] rpn_r;
    logic [63:0] rsci_r;
    logic rx_end;
    logic too_short;
    logic bad_ver;
    logic bad_sl;
    logic kay;
    logic [15:0] pos_inc;

    assign idx = rx_in_sof ? 16'h0000 : pos_r;
    assign pos_inc = (idx == 16'hFFFF) ? idx : idx + 16'h0001;
    assign rx_end = rx_in_valid && rx_in_eof;
    assign too_short = pos_inc < ({12'h000, mssf_pkg::ADDR_LEN}
        + mssf_pkg::MIN_MPDU);
    assign bad_ver = rtci_r[mssf_pkg::TCI_V];
    assign bad_sl = rsl_r[7:6] != mssf_pkg::SL_RSVD;
    assign kay = rtci_r[mssf_pkg::TCI_E] && !rtci_r[mssf_pkg::TCI_C];

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pos_r <= 16'h0000;
            et_hi_r <= 8'h00;
            is_sec_r <= 1'b0;
            rtci_r <= 8'h00;
            rsl_r <= 8'h00;
            rpn_r <= 32'h0;
            rsci_r <= 64'h0;
        end
        else if (rx_in_valid)
        begin
            pos_r <= pos_inc;
            if (idx == 16'h0000)
                is_sec_r <= 1'b0;
            if (idx == mssf_pkg::POS_ETYPE_HI)
                et_hi_r <= rx_in_data;
            if (idx == mssf_pkg::POS_ETYPE_LO)
                is_sec_r <= {et_hi_r, rx_in_data}
                    == mssf_pkg::SEC_ETYPE;
            if (is_sec_r && idx == mssf_pkg::POS_TCI)
                rtci_r <= rx_in_data;
            if (is_sec_r && idx == mssf_pkg::POS_SL)
                rsl_r <= rx_in_data;
            if (is_sec_r && idx >= mssf_pkg::POS_PN_FIRST
                && idx <= mssf_pkg::POS_PN_LAST)
                rpn_r <= {rpn_r[23:0], rx_in_data};
            if (is_sec_r && rtci_r[mssf_pkg::TCI_SC]
                && idx >= mssf_pkg::POS_SCI_FIRST
                && idx <= mssf_pkg::POS_SCI_LAST)
                rsci_r <= {rsci_r[55:0], rx_in_data};
        end
    end

    // ****************************************
    // Receive outputs
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rx_out_valid <= 1'b0;
            rx_out_data <= 8'h00;
            rx_out_sof <= 1'b0;
            rx_out_eof <= 1'b0;
            rx_status_valid <= 1'b0;
            rx_secured <= 1'b0;
            rx_kay <= 1'b0;
            rx_drop <= 1'b0;
            rx_encrypted <= 1'b0;
            rx_changed <= 1'b0;
            rx_an <= 2'h0;
            rx_sl <= 6'h00;
            rx_pn <= 32'h0;
            rx_sci <= 64'h0;
        end
        else
        begin
            rx_out_valid <= rx_in_valid;
            rx_out_data <= rx_in_data;
            rx_out_sof <= rx_in_valid && rx_in_sof;
            rx_out_eof <= rx_end;
            rx_status_valid <= rx_end;
            if (rx_end)
            begin
                rx_secured <= is_sec_r;
                rx_kay <= is_sec_r && kay;
                rx_drop <= is_sec_r && !kay
                    && (bad_ver || too_short || bad_sl);
                rx_encrypted <= is_sec_r && rtci_r[mssf_pkg::TCI_E];
                rx_changed <= is_sec_r && rtci_r[mssf_pkg::TCI_C];
                rx_an <= rtci_r[1:0];
                rx_sl <= rsl_r[5:0];
                rx_pn <= rpn_r;
                rx_sci <= rtci_r[mssf_pkg::TCI_SC] ? rsci_r : 64'h0;
            end
        end
    end

    mssf_iv_gen u_rx_iv (
        .clk(clk),
        .resetn(resetn),
        .capture(rx_end && is_sec_r && !kay),
        .sci(rtci_r[mssf_pkg::TCI_SC] ? rsci_r : 64'h0),
        .pn(rpn_r),
        .iv(rx_iv)
    );

endmodule // mssf_framer

//--- mssf_checker.sv
// Port checker of the security tag framer.
`timescale 1ns/1ps
module mssf_checker (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Watched ports.
    input wire logic pn_load,
    input wire logic [31:0] pn_load_value,
    input wire logic tx_out_valid,
    input wire logic [7:0] tx_out_data,
    input wire logic tx_out_sof,
    input wire logic [31:0] tx_pn,
    input wire logic rx_in_valid,
    input wire logic [7:0] rx_in_data,
    input wire logic rx_in_sof,
    input wire logic rx_in_eof,
    input wire logic rx_out_valid,
    input wire logic [7:0] rx_out_data,
    input wire logic rx_status_valid,
    input wire logic rx_secured,
    input wire logic rx_kay,
    input wire logic rx_drop,
    input wire logic rx_encrypted,
    input wire logic rx_changed,
    input wire logic [1:0] rx_an,
    input wire logic [5:0] rx_sl
);
    // ****************************************
    // Byte indices and captured tag bytes.
    // ****************************************
    logic [15:0] oidx_r;
    logic [15:0] ridx_r;
    logic [7:0] tci_r;
    logic [7:0] sl_r;
    wire [15:0] ridx = rx_in_sof ? 16'h0000 : ridx_r;
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            oidx_r <= 16'h0000;
            ridx_r <= 16'h0000;
            tci_r <= 8'h00;
            sl_r <= 8'h00;
        end
        else
        begin
            if (tx_out_valid)
                oidx_r <= tx_out_sof ? 16'h0001 : oidx_r + 16'h0001;
            if (rx_in_valid)
                ridx_r <= ridx + 16'h0001;
            if (rx_in_valid && ridx == 16'h000E)
                tci_r <= rx_in_data;
            if (rx_in_valid && ridx == 16'h000F)
                sl_r <= rx_in_data;
        end
    end
    // ****************************************
    // Assertions.
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence tag_start_s;
        tx_out_valid && !tx_out_sof && oidx_r == 16'h000C &&
        tx_out_data == 8'h88 ##1 tx_out_valid && tx_out_data == 8'hE5;
    endsequence
    tci_flags_a: assert property (tag_start_s |=>
        tx_out_valid && tx_out_data[7:6] == 2'h0 &&
        tx_out_data[4] == 1'b0 && tx_out_data[3] == tx_out_data[2])
        else $error("tag control flags wrong");
    sl_reserved_a: assert property (tag_start_s ##1 tx_out_valid |=>
        tx_out_valid && tx_out_data[7:6] == 2'h0)
        else $error("short length reserved bits set");
    pn_step_a: assert property (tx_pn != $past(tx_pn) &&
        $past(resetn) && !$past(pn_load) |-> tx_pn == $past(tx_pn) + 32'h1)
        else $error("packet number jumped");
    pn_load_a: assert property (pn_load |=>
        tx_pn == $past(pn_load_value))
        else $error("packet number not loaded");
    rx_copy_a: assert property (rx_in_valid |=>
        rx_out_valid && rx_out_data == $past(rx_in_data))
        else $error("receive byte altered");
    rx_status_a: assert property (rx_in_valid && rx_in_eof |=>
        rx_status_valid)
        else $error("receive status missing");
    kay_class_a: assert property (rx_status_valid |->
        rx_kay == (rx_secured && rx_encrypted && !rx_changed))
        else $error("key agreement class wrong");
    tag_fields_a: assert property (rx_status_valid &&
        rx_secured |-> rx_an == tci_r[1:0] && rx_encrypted == tci_r[3] &&
        rx_changed == tci_r[2] && rx_sl == sl_r[5:0])
        else $error("receive tag fields wrong");
    version_drop_a: assert property (rx_status_valid && rx_secured &&
        !rx_kay && tci_r[7] |-> rx_drop)
        else $error("version frame not dropped");
endmodule // mssf_checker
bind mssf_framer mssf_checker mssf_checker_inst (.clk, .resetn, .pn_load,
    .pn_load_value, .tx_out_valid, .tx_out_data, .tx_out_sof, .tx_pn,
    .rx_in_valid, .rx_in_data, .rx_in_sof, .rx_in_eof, .rx_out_valid,
    .rx_out_data, .rx_status_valid, .rx_secured, .rx_kay, .rx_drop,
    .rx_encrypted, .rx_changed, .rx_an, .rx_sl);

//--- mssf_peer.sv
// Behavioural remote peer across the link of the framer.
`timescale 1ns/1ps
module mssf_peer (
    // Clock.
    input wire logic clk,
    // Frames from the framer.
    input wire logic tx_out_valid,
    input wire logic [7:0] tx_out_data,
    input wire logic tx_out_sof,
    input wire logic tx_out_eof,
    // Frames to the framer.
    output logic rx_in_valid = 1'b0,
    output logic [7:0] rx_in_data = 8'h00,
    output logic rx_in_sof = 1'b0,
    output logic rx_in_eof = 1'b0
);
    logic [9:0] txq[$];
    always @(posedge clk)
        if (tx_out_valid)
            txq.push_back({tx_out_sof, tx_out_eof, tx_out_data});
    task automatic send_frame(input logic [15:0] et, input logic [7:0] tci,
        input logic [7:0] sl, input logic [31:0] pn, input logic [63:0] sci,
        input int n);
        logic [7:0] b;
        int k;
        for (k = 0; k < n; k++)
        begin
            b = 8'(k * 37 + 5);
            if (k == 12 || k == 13)
                b = et[(13 - k) * 8 +: 8];
            if (k == 14)
                b = tci;
            if (k == 15)
                b = sl;
            if (k >= 16 && k < 20)
                b = pn[(19 - k) * 8 +: 8];
            if (tci[5] && k >= 20 && k < 28)
                b = sci[(27 - k) * 8 +: 8];
            @(negedge clk);
            rx_in_valid = 1'b1;
            rx_in_data = b;
            rx_in_sof = k == 0;
            rx_in_eof = k == n - 1;
        end
        @(negedge clk);
        rx_in_valid = 1'b0;
        rx_in_sof = 1'b0;
        rx_in_eof = 1'b0;
        rx_in_data = ~rx_in_data;
    endtask
endmodule // mssf_peer

//--- tb.sv
// Self-checking testbench of the security tag framer.
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, resetn = 1'b0, tx_in_valid = 1'b0, tx_in_sof = 1'b0;
    logic tx_in_eof = 1'b0, tx_secure = 1'b0, tx_encrypt = 1'b0;
    logic tx_include_sci = 1'b0, pn_load = 1'b0;
    logic [1:0] tx_an = 2'h0;
    logic [7:0] tx_in_data = 8'h00;
    logic [15:0] tx_user_len = 16'h0000, port_num = 16'h0000;
    logic [31:0] pn_load_value = 32'h00000000, exp_pn = 32'h00000001;
    logic [47:0] src_mac = 48'h000000000000;
    logic [127:0] tx_icv = 128'h0;
    logic tx_in_ready, tx_out_valid, tx_out_sof, tx_out_eof, rx_in_valid;
    logic rx_in_sof, rx_in_eof, rx_out_valid, rx_out_sof, rx_out_eof;
    logic rx_status_valid, rx_secured, rx_kay, rx_drop, rx_encrypted;
    logic rx_changed;
    logic [1:0] rx_an;
    logic [5:0] rx_sl;
    logic [7:0] tx_out_data, rx_in_data, rx_out_data;
    logic [31:0] tx_pn, rx_pn;
    logic [63:0] rx_sci;
    logic [95:0] tx_iv, rx_iv;
    logic [9:0] exp_q[$];
    int seed = 27;
    int n_mismatch = 0;
    int n_checks = 0;
    mssf_framer mssf_framer_inst (.clk, .resetn, .tx_in_valid, .tx_in_data,
        .tx_in_sof, .tx_in_eof, .tx_in_ready, .tx_secure, .tx_encrypt,
        .tx_include_sci, .tx_an, .tx_user_len, .tx_icv, .src_mac, .port_num,
        .pn_load, .pn_load_value, .tx_out_valid, .tx_out_data, .tx_out_sof,
        .tx_out_eof, .tx_pn, .tx_iv, .rx_in_valid, .rx_in_data, .rx_in_sof,
        .rx_in_eof, .rx_out_valid, .rx_out_data, .rx_out_sof, .rx_out_eof,
        .rx_status_valid, .rx_secured, .rx_kay, .rx_drop, .rx_encrypted,
        .rx_changed, .rx_an, .rx_sl, .rx_pn, .rx_sci, .rx_iv);
    mssf_peer mssf_peer_inst (.clk, .tx_out_valid, .tx_out_data, .tx_out_sof,
        .tx_out_eof, .rx_in_valid, .rx_in_data, .rx_in_sof, .rx_in_eof);
    initial
    begin
        forever #10 clk = ~clk;
    end
    function automatic logic [7:0] tci_f(input logic c, input logic e,
                                         input logic [1:0] a);
        return {2'h0, c, 1'b0, e, e, a};
    endfunction
    function automatic logic [7:0] sl_f(input int n);
        return (n < 48) ? 8'(n) : 8'h00;
    endfunction
    task automatic chk(input string nm, input logic [127:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic hang(input string nm);
        n_mismatch++;
        $display("[ERR] %s expected handshake seen timeout", nm);
        complete_run();
    endtask
    task automatic put(input logic e, input logic [7:0] d);
        exp_q.push_back({exp_q.size() == 0, e, d});
    endtask
    task automatic load_pn(input logic [31:0] v);
        @(negedge clk);
        pn_load = 1'b1;
        pn_load_value = v;
        @(negedge clk);
        pn_load = 1'b0;
        exp_pn = v;
        chk("tx pn load", tx_pn, v);
    endtask
    task automatic run_tx(input logic s, e, c, input logic [1:0] a,
                          input int n);
        logic [7:0] d[$];
        logic [63:0] sci;
        int k;
        int w;
        @(negedge clk);
        src_mac = 48'({$random(seed), $random(seed)});
        port_num = 16'($random(seed));
        tx_secure = s;
        tx_encrypt = e;
        tx_include_sci = c;
        tx_an = a;
        tx_user_len = 16'(n);
        tx_icv = {$random(seed), $random(seed), $random(seed), $random(seed)};
        sci = {src_mac, port_num};
        exp_q.delete();
        mssf_peer_inst.txq.delete();
        for (k = 0; k < 12 + n; k++)
            d.push_back(8'($random(seed)) & 8'h7F);
        for (k = 0; k < 12; k++)
            put(1'b0, d[k]);
        if (s)
        begin
            put(1'b0, 8'h88);
            put(1'b0, 8'hE5);
            put(1'b0, tci_f(c, e, a));
            put(1'b0, sl_f(n));
            for (k = 0; k < 4; k++)
                put(1'b0, exp_pn[(3 - k) * 8 +: 8]);
            for (k = 0; k < 8 && c; k++)
                put(1'b0, sci[(7 - k) * 8 +: 8]);
        end
        for (k = 12; k < 12 + n; k++)
            put(!s && k == 11 + n, d[k]);
        for (k = 0; k < 16 && s; k++)
            put(k == 15, tx_icv[(15 - k) * 8 +: 8]);
        for (k = 0; k < 12 + n; k++)
        begin
            tx_in_valid = 1'b1;
            tx_in_data = d[k];
            tx_in_sof = k == 0;
            tx_in_eof = k == 11 + n;
            for (w = 0; w < 40 && tx_in_ready !== 1'b1; w++)
                @(negedge clk);
            if (w == 40)
                hang("tx_in_ready");
            @(negedge clk);
        end
        tx_in_valid = 1'b0;
        repeat (24) @(negedge clk);
        chk("tx length", mssf_peer_inst.txq.size(), exp_q.size());
        for (k = 0; k < exp_q.size() && k < mssf_peer_inst.txq.size(); k++)
            chk("tx byte", mssf_peer_inst.txq[k], exp_q[k]);
        if (s)
        begin
            chk("tx iv", tx_iv, {sci, exp_pn});
            exp_pn++;
        end
        chk("tx pn", tx_pn, exp_pn);
    endtask
    task automatic run_rx(input logic [15:0] et, input logic [7:0] tci, sl,
                          input int n);
        logic [31:0] pn;
        logic [63:0] sci;
        logic sec, kay, drop;
        int w;
        pn = $random(seed);
        sci = {$random(seed), $random(seed)};
        sec = n >= 14 && et == 16'h88E5;
        kay = sec && tci[3] && !tci[2];
        drop = sec && !kay && (tci[7] || n < 29 || sl[7:6] != 2'h0);
        mssf_peer_inst.send_frame(et, tci, sl, pn, sci, n);
        for (w = 0; w < 60 && rx_status_valid !== 1'b1; w++)
            @(negedge clk);
        if (w == 60)
            hang("rx_status_valid");
        chk("rx out sof eof", {rx_out_sof, rx_out_eof}, 2'h1);
        chk("rx secured", rx_secured, sec);
        chk("rx kay", rx_kay, kay);
        chk("rx drop", rx_drop, drop);
        @(negedge clk);
        if (sec && !drop)
            chk("rx pn", rx_pn, pn);
        if (sec && !drop)
            chk("rx sci", rx_sci, tci[5] ? sci : 64'h0);
        if (sec && !drop && !kay)
            chk("rx iv", rx_iv, {tci[5] ? sci : 64'h0, pn});
    endtask
    logic [47:0] rtab [9] = '{48'h0800_0C00_0028, 48'h88E5_0C00_004C,
        48'h88E5_2D14_0038, 48'h88E5_0800_0028, 48'h88E5_0408_0028,
        48'h88E5_8C00_0028, 48'h88E5_0C0D_001C, 48'h88E5_0E0D_001D,
        48'h88E5_0F45_0028};
    initial
    begin : main
        int i;
        logic [31:0] r;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        chk("reset tx_pn", tx_pn, 32'h1);
        chk("reset ready", tx_in_ready, 1'b1);
        chk("reset tx valid", tx_out_valid, 1'b0);
        run_tx(1'b1, 1'b1, 1'b0, 2'h0, 47);
        run_tx(1'b1, 1'b1, 1'b1, 2'h3, 48);
        run_tx(1'b1, 1'b0, 1'b1, 2'h2, 1);
        run_tx(1'b0, 1'b0, 1'b0, 2'h1, 20);
        load_pn(32'hFFFFFFFF);
        for (i = 0; i < 6; i++)
        begin
            r = $random(seed);
            run_tx(r[0], r[1], r[2], r[4:3], int'(r[10:5]) % 60 + 1);
        end
        resetn = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
        chk("mid reset tx_pn", tx_pn, 32'h1);
        load_pn(32'h00000001);
        for (i = 0; i < 9; i++)
            run_rx(rtab[i][47:32], rtab[i][31:24], rtab[i][23:16],
                   int'(rtab[i][15:0]));
        for (i = 0; i < 8; i++)
        begin
            r = $random(seed);
            run_rx(r[0] ? 16'h88E5 : 16'h0800, r[15:8], {2'h0, r[21:16]},
                   int'(r[27:22]) + 29);
        end
        complete_run();
    end
endmodule // tb
